// >>> xsc_pkg.sv
package xsc_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_OPERAND = 8'h08;
  localparam logic [7:0] ADDR_BITRUN = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_STACK = 8'h14;

  // field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SRC_LSB = 4;
  localparam int BITRUN_CNT_LSB = 16;
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_NEG = 1;
  localparam int FLAG_LESS = 2;
  localparam int FLAG_EQUAL = 3;
  localparam int FLAG_GREATER = 4;
  localparam int FLAG_BUSY = 5;

  // reset values
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;

  // bit run length limits
  localparam int BITRUN_MIN = 1;
  localparam int BITRUN_MAX = 32;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    XOR_WITH_STACK_OP = 3'b001,
    WORD_COMPARE_OP = 3'b010,
    DOUBLE_COMPARE_OP = 3'b011,
    BIT_RUN_COMPARE_OP = 3'b100
  } op_t;

  typedef enum logic [1:0] {
    SRC_DIRECT = 2'b00,
    SRC_POINTER = 2'b01,
    SRC_CONST = 2'b10
  } src_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_XOR = 3'b001,
    S_PTR = 3'b010,
    S_LO = 3'b011,
    S_HI = 3'b100,
    S_BITS = 3'b101,
    S_JUDGE = 3'b110
  } fsm_t;

endpackage

// >>> acc_stack.sv
module acc_stack #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top,
  output logic [$clog2(DEPTH+1)-1:0] depth
);

  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [CW-1:0] cnt;
  } stk_t;

  stk_t s_r;
  stk_t s_nxt;
  logic [DEPTH-1:0][W-1:0] pop_val;
  logic [DEPTH-1:0][W-1:0] push_val;

  ////////////////////////////////////////////////////////////////////////////
  // shifted images of the stack, one entry per slot
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      if (i == DEPTH - 1) begin : g_last
        assign pop_val[i] = '0;
      end else begin : g_mid
        assign pop_val[i] = s_r.ent[i+1];
      end
      if (i == 0) begin : g_first
        assign push_val[i] = push_data;
      end else begin : g_rest
        assign push_val[i] = s_r.ent[i-1];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pop wins over push, entries move up toward the top
  always_comb begin
    s_nxt = s_r;
    if (pop) begin
      s_nxt.ent = pop_val;
      if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - 1'b1;
    end else if (push) begin
      s_nxt.ent = push_val;
      if (s_r.cnt != CW'(DEPTH)) s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign top = s_r.ent[0]; // registered top of stack
  assign depth = s_r.cnt;

endmodule

// >>> bit_gather.sv
module bit_gather (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] start_addr,
  input wire logic [5:0] count,
  input wire logic bit_rdata,
  output logic [15:0] bit_addr,
  output logic bit_rd,
  output logic done,
  output logic [31:0] value
);

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [5:0] issued;
    logic [5:0] got;
    logic [15:0] nxt_addr;
    logic [15:0] addr;
    logic rd;
    logic take;
    logic done;
    logic [31:0] value;
  } gat_t;

  gat_t s_r;
  gat_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // one bit read per cycle, first address lands in bit 0
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.take = s_r.rd; // data follows the read by one cycle
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = count;
      s_nxt.issued = '0;
      s_nxt.got = '0;
      s_nxt.nxt_addr = start_addr;
      s_nxt.value = '0;
      s_nxt.take = 1'b0;
    end else if (s_r.busy) begin
      if (s_r.issued < s_r.cnt) begin
        s_nxt.rd = 1'b1;
        s_nxt.addr = s_r.nxt_addr;
        s_nxt.nxt_addr = s_r.nxt_addr + 16'h0001;
        s_nxt.issued = s_r.issued + 6'h01;
      end
      if (s_r.take) begin
        s_nxt.value[s_r.got[4:0]] = bit_rdata;
        s_nxt.got = s_r.got + 6'h01;
        if (s_r.got + 6'h01 == s_r.cnt) begin
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign bit_addr = s_r.addr;
  assign bit_rd = s_r.rd;
  assign done = s_r.done;
  assign value = s_r.value;

endmodule

// >>> xor_stack_and_compare_unit.sv
// The Wishbone slave port and the address map were decided locally.
module xor_stack_and_compare_unit #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  output logic [15:0] DMEM_ADDR,
  output logic DMEM_RD,
  input wire logic [15:0] DMEM_RDATA,
  input wire logic DMEM_VALID,
  output logic [15:0] BIT_ADDR,
  output logic BIT_RD,
  input wire logic BIT_RDATA,
  output logic ZERO_FLAG,
  output logic NEGATIVE_FLAG,
  output logic LESS_FLAG,
  output logic EQUAL_FLAG,
  output logic GREATER_FLAG,
  output logic BUSY
);

  localparam int DW = $clog2(STACK_DEPTH+1);

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] operand;
    logic [15:0] bit_start;
    logic [5:0] bit_count;
    xsc_pkg::op_t op;
    xsc_pkg::src_t src;
    xsc_pkg::fsm_t state;
    logic [31:0] opnd;
    logic [15:0] daddr;
    logic dmem_rd;
    logic gstart;
    logic push;
    logic pop;
    logic [31:0] push_data;
    logic zero;
    logic neg;
    logic less;
    logic equal;
    logic greater;
    logic ack;
    logic [31:0] rdat;
  } unit_t;

  unit_t s_r;
  unit_t s_nxt;
  logic [31:0] stack_top;
  logic [DW-1:0] stack_depth;
  logic g_done;
  logic [31:0] g_value;
  logic bus_hit;
  logic busy;
  logic [31:0] lhs_v;
  logic [31:0] rhs_v;
  logic [31:0] xor_res;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  acc_stack #(
    .W(32),
    .DEPTH(STACK_DEPTH)
  ) acc_stack_i (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .push(s_r.push),
    .pop(s_r.pop),
    .push_data(s_r.push_data),
    .top(stack_top),
    .depth(stack_depth)
  );

  bit_gather bit_gather_i (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .start(s_r.gstart),
    .start_addr(s_r.bit_start),
    .count(s_r.bit_count),
    .bit_rdata(BIT_RDATA),
    .bit_addr(BIT_ADDR),
    .bit_rd(BIT_RD),
    .done(g_done),
    .value(g_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode, busy, and operand shaping for the comparator
  assign bus_hit = CYC_I & STB_I;
  // busy covers the one-cycle push, pop and start strobes too
  assign busy = (s_r.state != xsc_pkg::S_IDLE) | s_r.pop | s_r.push | s_r.gstart;
  assign xor_res = s_r.acc ^ stack_top;
  // low half only
  // word compare zero-extends both sides
  assign lhs_v = (s_r.op == xsc_pkg::WORD_COMPARE_OP) ? {16'h0000, s_r.acc[15:0]} : s_r.acc;
  assign rhs_v = (s_r.op == xsc_pkg::WORD_COMPARE_OP) ? {16'h0000, s_r.opnd[15:0]} : s_r.opnd;

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, command launch, operand fetch, execute
  always_comb begin
    s_nxt = s_r;
    s_nxt.dmem_rd = 1'b0;
    s_nxt.gstart = 1'b0;
    s_nxt.push = 1'b0;
    s_nxt.pop = 1'b0;
    s_nxt.ack = bus_hit & ~s_r.ack;
    // read data captured as ack rises
    if (bus_hit & ~s_r.ack) begin
      case (ADR_I)
        xsc_pkg::ADDR_ACC: s_nxt.rdat = s_r.acc;
        xsc_pkg::ADDR_CMD: s_nxt.rdat = {26'h000_0000, s_r.src, 1'b0, s_r.op};
        xsc_pkg::ADDR_OPERAND: s_nxt.rdat = s_r.operand;
        xsc_pkg::ADDR_BITRUN: s_nxt.rdat = {10'h000, s_r.bit_count, s_r.bit_start};
        xsc_pkg::ADDR_FLAGS: s_nxt.rdat = {26'h000_0000, busy, s_r.greater, s_r.equal,
                                           s_r.less, s_r.neg, s_r.zero};
        xsc_pkg::ADDR_STACK: s_nxt.rdat = 32'(stack_depth);
        default: s_nxt.rdat = 32'h0000_0000;
      endcase
    end
    // writes take effect on the edge where ack is seen; refused while busy
    // a refused write is still acked, so software polls busy first
    if (bus_hit & s_r.ack & WE_I & ~busy) begin
      case (ADR_I)
        xsc_pkg::ADDR_ACC: s_nxt.acc = lane_merge(s_r.acc, DAT_I, SEL_I);
        xsc_pkg::ADDR_OPERAND: s_nxt.operand = lane_merge(s_r.operand, DAT_I, SEL_I);
        xsc_pkg::ADDR_BITRUN: begin
          if (SEL_I[0]) s_nxt.bit_start[7:0] = DAT_I[7:0];
          if (SEL_I[1]) s_nxt.bit_start[15:8] = DAT_I[15:8];
          if (SEL_I[2]) s_nxt.bit_count = DAT_I[xsc_pkg::BITRUN_CNT_LSB +: 6];
        end
        xsc_pkg::ADDR_STACK: begin
          s_nxt.push = 1'b1;
          s_nxt.push_data = DAT_I;
        end
        xsc_pkg::ADDR_CMD: begin
          if (SEL_I[0]) begin
            s_nxt.op = xsc_pkg::op_t'(DAT_I[xsc_pkg::CMD_OP_LSB +: 3]);
            s_nxt.src = xsc_pkg::src_t'(DAT_I[xsc_pkg::CMD_SRC_LSB +: 2]);
            case (xsc_pkg::op_t'(DAT_I[xsc_pkg::CMD_OP_LSB +: 3]))
              xsc_pkg::XOR_WITH_STACK_OP: s_nxt.state = xsc_pkg::S_XOR;
              xsc_pkg::WORD_COMPARE_OP, xsc_pkg::DOUBLE_COMPARE_OP: begin
                case (xsc_pkg::src_t'(DAT_I[xsc_pkg::CMD_SRC_LSB +: 2]))
                  xsc_pkg::SRC_CONST: begin
                    s_nxt.opnd = s_r.operand;
                    s_nxt.state = xsc_pkg::S_JUDGE;
                  end
                  xsc_pkg::SRC_POINTER: begin
                    s_nxt.daddr = s_r.operand[15:0];
                    s_nxt.dmem_rd = 1'b1;
                    s_nxt.state = xsc_pkg::S_PTR;
                  end
                  default: begin
                    s_nxt.daddr = s_r.operand[15:0];
                    s_nxt.dmem_rd = 1'b1;
                    s_nxt.state = xsc_pkg::S_LO;
                  end
                endcase
              end
              // start address and count from the bit run register
              xsc_pkg::BIT_RUN_COMPARE_OP: begin
                s_nxt.gstart = 1'b1;
                s_nxt.state = xsc_pkg::S_BITS;
              end
              default: s_nxt.state = xsc_pkg::S_IDLE;
            endcase
          end
        end
        default: ;
      endcase
    end
    // operation sequencer
    case (s_r.state)
      xsc_pkg::S_IDLE: ;
      xsc_pkg::S_XOR: begin
        // empty stack reads as zero, so acc keeps its value
        s_nxt.acc = xor_res;
        s_nxt.pop = 1'b1;
        s_nxt.zero = (xor_res == 32'h0000_0000);
        s_nxt.neg = xor_res[31];
        s_nxt.state = xsc_pkg::S_IDLE;
      end
      xsc_pkg::S_PTR: begin
        if (DMEM_VALID) begin
          s_nxt.daddr = DMEM_RDATA;
          s_nxt.dmem_rd = 1'b1;
          s_nxt.state = xsc_pkg::S_LO;
        end
      end
      xsc_pkg::S_LO: begin
        if (DMEM_VALID) begin
          s_nxt.opnd = {16'h0000, DMEM_RDATA};
          // second consecutive word is the high half
          if (s_r.op == xsc_pkg::DOUBLE_COMPARE_OP) begin
            s_nxt.daddr = s_r.daddr + 16'h0001;
            s_nxt.dmem_rd = 1'b1;
            s_nxt.state = xsc_pkg::S_HI;
          end else begin
            s_nxt.state = xsc_pkg::S_JUDGE;
          end
        end
      end
      xsc_pkg::S_HI: begin
        if (DMEM_VALID) begin
          s_nxt.opnd[31:16] = DMEM_RDATA;
          s_nxt.state = xsc_pkg::S_JUDGE;
        end
      end
      // assembled bit run is the operand
      xsc_pkg::S_BITS: begin
        // gather block runs the bit link meanwhile
        if (g_done) begin
          s_nxt.opnd = g_value;
          s_nxt.state = xsc_pkg::S_JUDGE;
        end
      end
      xsc_pkg::S_JUDGE: begin
        s_nxt.less = (lhs_v < rhs_v);
        s_nxt.equal = (lhs_v == rhs_v);
        s_nxt.greater = (lhs_v > rhs_v);
        s_nxt.state = xsc_pkg::S_IDLE;
      end
      default: s_nxt.state = xsc_pkg::S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while clock enable is low
  // flags only change when rewritten
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.acc <= xsc_pkg::ACC_RESET;
      s_r.operand <= xsc_pkg::OPERAND_RESET;
      s_r.state <= xsc_pkg::S_IDLE;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign DAT_O = s_r.rdat;
  assign ACK_O = s_r.ack;
  assign DMEM_ADDR = s_r.daddr;
  assign DMEM_RD = s_r.dmem_rd;
  // flags are plain registers, none sticky
  assign ZERO_FLAG = s_r.zero;
  assign NEGATIVE_FLAG = s_r.neg;
  assign LESS_FLAG = s_r.less;
  assign EQUAL_FLAG = s_r.equal;
  assign GREATER_FLAG = s_r.greater;
  assign BUSY = busy; // combinational from registered state

endmodule

// >>> xsc_assertions.sv
module xsc_assertions (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic DMEM_RD,
  input wire logic [15:0] BIT_ADDR,
  input wire logic BIT_RD,
  input wire logic ZERO_FLAG,
  input wire logic NEGATIVE_FLAG,
  input wire logic LESS_FLAG,
  input wire logic EQUAL_FLAG,
  input wire logic GREATER_FLAG,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////
  // bus request and back-to-back bit fetches
  sequence bus_req;
    CYC_I && STB_I && !ACK_O && CE;
  endsequence
  sequence bit_pair;
    BIT_RD && CE ##1 BIT_RD;
  endsequence
  ////////////////////////////////////////////////////////////////
  // bus handshake and data memory read pulse
  a_ack_answer: assert property (bus_req |=> ACK_O) else $error("ack missing");
  a_ack_pulse: assert property (ACK_O && CE |=> !ACK_O) else $error("ack too long");
  a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("stray ack");
  a_dmem_pulse: assert property (DMEM_RD && CE |=> !DMEM_RD) else $error("read not a pulse");
  // flag relations, busy timeout and bit address step
  a_one_result: assert property (
    $onehot0({LESS_FLAG, EQUAL_FLAG, GREATER_FLAG})) else $error("two compare flags");
  a_zero_not_neg: assert property (
    ZERO_FLAG |-> !NEGATIVE_FLAG) else $error("zero and negative");
  a_flags_hold: assert property (
    !$past(BUSY) |-> $stable({ZERO_FLAG, NEGATIVE_FLAG, LESS_FLAG, EQUAL_FLAG, GREATER_FLAG}))
    else $error("flag moved while idle");
  a_busy_ends: assert property ($rose(BUSY) |-> ##[1:300] !BUSY) else $error("busy hangs");
  a_bit_step: assert property (
    bit_pair |-> BIT_ADDR == $past(BIT_ADDR) + 16'h0001) else $error("bit address step");
endmodule
bind xor_stack_and_compare_unit xsc_assertions xsc_assertions_i (.CLK, .SYS_RST, .CE, .CYC_I,
  .STB_I, .ACK_O, .DMEM_RD, .BIT_ADDR, .BIT_RD, .ZERO_FLAG, .NEGATIVE_FLAG, .LESS_FLAG,
  .EQUAL_FLAG, .GREATER_FLAG, .BUSY);

// >>> seq_mem_model.sv
module seq_mem_model (
  input wire logic clk,
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_rd,
  output logic [15:0] dmem_rdata,
  output logic dmem_valid,
  input wire logic [15:0] bit_addr,
  input wire logic bit_rd,
  output logic bit_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:15];
  logic [15:0] held;
  logic [63:0] bits;
  int lat = 1;
  int cnt = 0;
  initial begin
    dmem_rdata = 16'h0000;
    dmem_valid = 1'b0;
    bit_rdata = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // word answered lat cycles late, bus scrambled between answers
  always @(posedge clk) begin
    dmem_valid <= 1'b0;
    dmem_rdata <= ~dmem_rdata;
    if (dmem_rd) begin
      cnt <= lat;
      held <= mem[dmem_addr[3:0]];
    end else if (cnt == 1) begin
      cnt <= 0;
      dmem_valid <= 1'b1;
      dmem_rdata <= held;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // bit valid only the cycle after its fetch
  always @(posedge clk) begin
    bit_rdata <= bit_rd ? bits[bit_addr[5:0]] : ~bit_rdata;
  end
endmodule

// >>> xor_stack_and_compare_unit_tb.sv
module xor_stack_and_compare_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, we, cyc, stb, ack, dmem_rd, dmem_valid, bit_rd, bit_rdata;
  logic [7:0] adr;
  logic [31:0] dat_w, dat_r;
  logic [15:0] dmem_addr, dmem_rdata, bit_addr;
  logic [4:0] flag_pins;
  logic busy_pin;
  int mismatches = 0;
  int comparisons = 0;
  localparam logic [7:0] oper_adr = xsc_pkg::ADDR_OPERAND;
  localparam logic [7:0] brun_adr = xsc_pkg::ADDR_BITRUN;
  xor_stack_and_compare_unit xor_stack_and_compare_unit_i (
    .CLK(clk), .SYS_RST(rst), .CE(1'b1), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
    .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .DMEM_ADDR(dmem_addr), .DMEM_RD(dmem_rd), .DMEM_RDATA(dmem_rdata),
    .DMEM_VALID(dmem_valid), .BIT_ADDR(bit_addr), .BIT_RD(bit_rd), .BIT_RDATA(bit_rdata),
    .ZERO_FLAG(flag_pins[0]), .NEGATIVE_FLAG(flag_pins[1]), .LESS_FLAG(flag_pins[2]),
    .EQUAL_FLAG(flag_pins[3]), .GREATER_FLAG(flag_pins[4]), .BUSY(busy_pin));
  seq_mem_model seq_mem_model_i (
    .clk(clk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata),
    .dmem_valid(dmem_valid), .bit_addr(bit_addr), .bit_rd(bit_rd), .bit_rdata(bit_rdata));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  // bus cycle, comparison and operation helpers
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    // no local timeout; ack ends this wait, or the watchdog if ack never comes
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // start an operation, then poll busy down
  task automatic run(input logic [31:0] c);
    logic [31:0] q;
    wr(xsc_pkg::ADDR_CMD, c);
    q = 32'h0000_0020;
    while (q[xsc_pkg::FLAG_BUSY] !== 1'b0) begin
      wb(xsc_pkg::ADDR_FLAGS, 1'b0, 32'h0000_0000, q);
    end
  endtask
  task automatic cmpop(input logic [31:0] a, input logic [7:0] oa, input logic [31:0] o,
                       input logic [31:0] c, input logic [31:0] e);
    wr(xsc_pkg::ADDR_ACC, a);
    wr(oa, o);
    run(c);
    rchk(xsc_pkg::ADDR_FLAGS, e);
    chk(32'({busy_pin, flag_pins}), e);
    rchk(xsc_pkg::ADDR_ACC, a);
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    {we, cyc, stb, adr, dat_w} = '0;
    seq_mem_model_i.mem = '{2: 16'h1234, 3: 16'h0002, 4: 16'h0000, 5: 16'h8000,
                            6: 16'h1235, default: 16'h0000};
    seq_mem_model_i.bits = 64'h0123_4567_89AB_CDEF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(xsc_pkg::ADDR_FLAGS, 32'h0000_0000);
    rchk(xsc_pkg::ADDR_ACC, xsc_pkg::ACC_RESET);
    // two pushes, then two pops through xor
    wr(xsc_pkg::ADDR_STACK, 32'h8000_0000);
    wr(xsc_pkg::ADDR_STACK, 32'h0000_00F0);
    wr(xsc_pkg::ADDR_ACC, 32'h8000_00F0);
    run(32'h0000_0001);
    rchk(xsc_pkg::ADDR_ACC, 32'h8000_0000);
    rchk(xsc_pkg::ADDR_FLAGS, 32'h0000_0002);
    chk(32'({busy_pin, flag_pins}), 32'h0000_0002);
    rchk(xsc_pkg::ADDR_STACK, 32'h0000_0001);
    run(32'h0000_0001);
    rchk(xsc_pkg::ADDR_ACC, 32'h0000_0000);
    rchk(xsc_pkg::ADDR_FLAGS, 32'h0000_0001);
    chk(32'({busy_pin, flag_pins}), 32'h0000_0001);
    rchk(xsc_pkg::ADDR_STACK, 32'h0000_0000);
    // compares keep the zero flag set above
    cmpop(32'hFFFF_1234, oper_adr, 32'h0000_0002, 32'h0000_0002, 32'h0000_0009);
    cmpop(32'hABCD_0010, oper_adr, 32'h1234_0010, 32'h0000_0022, 32'h0000_0009);
    seq_mem_model_i.lat = 3;
    cmpop(32'h0000_1234, oper_adr, 32'h0000_0006, 32'h0000_0002, 32'h0000_0005);
    cmpop(32'h0000_1236, oper_adr, 32'h0000_0006, 32'h0000_0002, 32'h0000_0011);
    cmpop(32'h0000_1234, oper_adr, 32'h0000_0003, 32'h0000_0012, 32'h0000_0009);
    cmpop(32'h0002_1234, oper_adr, 32'h0000_0003, 32'h0000_0013, 32'h0000_0009);
    cmpop(32'h7FFF_FFFF, oper_adr, 32'h0000_0004, 32'h0000_0003, 32'h0000_0005);
    cmpop(32'h7FFF_FFFF, oper_adr, 32'h0000_0001, 32'h0000_0023, 32'h0000_0011);
    cmpop(32'hFFFF_FFFF, oper_adr, 32'hFFFF_FFFF, 32'h0000_0023, 32'h0000_0009);
    cmpop(32'h6789_ABCD, brun_adr, 32'h0020_0008, 32'h0000_0004, 32'h0000_0009);
    cmpop(32'h0000_0000, brun_adr, 32'h0001_0000, 32'h0000_0004, 32'h0000_0005);
    // xor on empty stack leaves the compare flag alone
    wr(xsc_pkg::ADDR_ACC, 32'h0000_0005);
    run(32'h0000_0001);
    rchk(xsc_pkg::ADDR_ACC, 32'h0000_0005);
    rchk(xsc_pkg::ADDR_FLAGS, 32'h0000_0004);
    chk(32'({busy_pin, flag_pins}), 32'h0000_0004);
    // reset after one completed push empties the stack and clears every flag
    wr(xsc_pkg::ADDR_STACK, 32'h0000_0001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(xsc_pkg::ADDR_STACK, 32'h0000_0000);
    rchk(xsc_pkg::ADDR_ACC, xsc_pkg::ACC_RESET);
    rchk(xsc_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk(32'({busy_pin, flag_pins}), 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    give_verdict();
  end
endmodule
